// ==== common/gdsm_pkg.sv ====
// Shared constants, state codes and state records of the gate driver serial master.
// Assumes a 40 MHz system clock and a separate, free-running link clock.
package gdsm_pkg;

  // Frame shape: every transfer carries exactly this many data bits
  localparam int FRAME_BITS = 16;
  localparam int BIT_IDX_W = 5;
  localparam logic [BIT_IDX_W-1:0] LAST_BIT = 5'h0_00F;

  // Serial clock target and its half period, in picoseconds
  localparam longint SCLK_HZ = 4000000;
  localparam longint SCLK_HALF_PS = 64'd1_000_000_000_000 / (2 * SCLK_HZ);

  // Phase counter width bounds the longest half period in link cycles
  localparam int CNT_W = 8;
  localparam int CNT_MAX = 255;

  // Idle levels of the link pins and reset values of the registers
  localparam logic CS_IDLE_N = 1'h1;
  localparam logic SCLK_IDLE = 1'h0;
  localparam logic DOUT_IDLE = 1'h0;
  localparam logic [FRAME_BITS-1:0] WORD_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [BIT_IDX_W-1:0] BIT_RST = 5'h0_0000;

  // Link engine states
  typedef enum logic [5:0] {
    LK_IDLE  = 6'h01,
    LK_LEAD  = 6'h02,
    LK_HIGH  = 6'h04,
    LK_LOW   = 6'h08,
    LK_TRAIL = 6'h10,
    LK_GAP   = 6'h20
  } gdsm_link_e;

  // State of the link-clock side
  typedef struct packed {
    gdsm_link_e st;
    logic [CNT_W-1:0] cnt;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic [FRAME_BITS-1:0] sh_tx;
    logic [FRAME_BITS-1:0] sh_rx;
    logic [FRAME_BITS-1:0] rx_word;
    logic req_seen;
    logic ack;
    logic sclk;
    logic cs_n;
    logic dout;
  } gdsm_link_s;

  // State of the system-clock side
  typedef struct packed {
    logic [FRAME_BITS-1:0] tx_word;
    logic [FRAME_BITS-1:0] rx_word;
    logic busy;
    logic done;
    logic req;
    logic ack_seen;
  } gdsm_sys_s;

endpackage

// ==== common/gdsm_sync_if.sv ====
// Carrier between the serial master and its input synchronisers.
// Assumes raw comes from another clock domain or a pin.
`timescale 1ns/10ps
interface gdsm_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  // Owner drives the raw level and reads the settled one
  modport feed (output raw, input clean);
  modport sync (input raw, output clean);
endinterface

// ==== hw/gdsm_sync.sv ====
// Three-stage input synchroniser with an agreement filter.
// Assumes raw is asynchronous to clk; clean changes only when stages two and three agree.
`timescale 1ns/10ps
module gdsm_sync
  import gdsm_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  gdsm_sync_if.sync port
);

  // A zero-width synchroniser has nothing to carry
  generate
    if (W < 1) begin : g_bad_width
      $error("gdsm_sync: width must be at least one");
    end
  endgenerate

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } gdsm_sync_s;

  gdsm_sync_s sync_q;
  gdsm_sync_s sync_d;

  // Stage one is read by stage two only, never by the filter
  always_comb begin
    sync_d = sync_q;
    sync_d.s1 = port.raw;
    sync_d.s2 = sync_q.s1;
    sync_d.s3 = sync_q.s2;
    for (int i = 0; i < W; i++) begin
      if (sync_q.s2[i] == sync_q.s3[i]) begin
        sync_d.q[i] = sync_q.s3[i];
      end
    end
  end

  // Constant reset only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_q <= '0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign port.clean = sync_q.q;

endmodule // gdsm_sync

// ==== hw/gdsm_master.sv ====
// Serial master for an isolated gate driver: 16-bit frames, mode 1, active-low select.
// Assumes software polls busy/done; link logic runs on link_clk, unrelated to sys_clk.
`timescale 1ns/10ps
module gdsm_master
  import gdsm_pkg::*;
#(
  parameter int LINK_PERIOD_PS = 48000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic start,
  input wire logic [FRAME_BITS-1:0] tx_data,
  input wire logic clear_done,
  output logic busy,
  output logic done,
  output logic [FRAME_BITS-1:0] rx_data,
  output logic sclk,
  output logic cs_n,
  output logic data_line_out,
  input wire logic data_line_in
);

  ////////////////////////////////////////////////////////////////////////////////
  // Timing

  // Half period rounds up so the serial clock never exceeds its target
  localparam longint HALF_RAW = (SCLK_HALF_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int HALF_CYC = (HALF_RAW < 1) ? 1 : int'(HALF_RAW);
  localparam logic [CNT_W-1:0] HALF_LOAD = CNT_W'(HALF_CYC - 1);

  // Input data reaches the engine four link cycles late; three-cycle halves keep it in the bit
  generate
    if (HALF_CYC < 3 || HALF_CYC > CNT_MAX) begin : g_bad_rate
      $error("gdsm_master: link clock too fast or too slow for the serial clock");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Link-domain reset release

  logic [1:0] link_rst_q;
  logic link_rst;

  // Asserts at once, releases two link edges after rst falls
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      link_rst_q <= 2'h3;
    end else begin
      link_rst_q <= {link_rst_q[0], 1'h0};
    end
  end

  assign link_rst = link_rst_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Crossings

  gdsm_sync_if #(.W(1)) req_if ();
  gdsm_sync_if #(.W(1)) din_if ();
  gdsm_sync_if #(.W(1)) ack_if ();

  gdsm_sys_s sys_q;
  gdsm_sys_s sys_d;
  gdsm_link_s link_q;
  gdsm_link_s link_d;

  // Request toggle into the link domain; tx_word is held while busy
  assign req_if.raw = sys_q.req;
  gdsm_sync #(.W(1)) u_req_sync (
    .clk(link_clk),
    .rst(link_rst),
    .port(req_if.sync)
  );

  // Returned data pin, filtered like any other pin
  assign din_if.raw = data_line_in;
  gdsm_sync #(.W(1)) u_din_sync (
    .clk(link_clk),
    .rst(link_rst),
    .port(din_if.sync)
  );

  // Completion toggle back; link rx_word is held until the next request
  assign ack_if.raw = link_q.ack;
  gdsm_sync #(.W(1)) u_ack_sync (
    .clk(sys_clk),
    .rst(rst),
    .port(ack_if.sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // System side: request, busy and sticky done

  logic ack_evt;
  assign ack_evt = ack_if.clean != sys_q.ack_seen;

  // Start is ignored while busy, so the held word cannot change mid-frame
  always_comb begin
    sys_d = sys_q;
    if (start && !sys_q.busy) begin
      sys_d.tx_word = tx_data;
      sys_d.req = ~sys_q.req;
      sys_d.busy = 1'h1;
    end
    if (clear_done) begin
      sys_d.done = 1'h0;
    end
    // Completion set wins over a clear in the same cycle
    if (ack_evt) begin
      sys_d.ack_seen = ack_if.clean;
      sys_d.rx_word = link_q.rx_word;
      sys_d.busy = 1'h0;
      sys_d.done = 1'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sys_q <= '{tx_word: WORD_RST, rx_word: WORD_RST, busy: 1'h0, done: 1'h0,
                 req: 1'h0, ack_seen: 1'h0};
    end else begin
      sys_q <= sys_d;
    end
  end

  assign busy = sys_q.busy;
  assign done = sys_q.done;
  assign rx_data = sys_q.rx_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Link side: frame engine

  logic req_evt;
  logic phase_end;
  assign req_evt = req_if.clean != link_q.req_seen;
  assign phase_end = link_q.cnt == CNT_RST;

  // Each phase lasts HALF_CYC link cycles; outputs change only at phase ends
  always_comb begin
    link_d = link_q;
    if (!phase_end) begin
      link_d.cnt = link_q.cnt - CNT_W'(1);
    end
    unique case (link_q.st)
      LK_IDLE: begin
        if (req_evt) begin
          link_d.req_seen = req_if.clean;
          link_d.sh_tx = sys_q.tx_word;
          link_d.cs_n = 1'h0;
          link_d.cnt = HALF_LOAD;
          link_d.bit_idx = BIT_RST;
          link_d.st = LK_LEAD;
        end
      end
      LK_LEAD: begin
        // First edge of bit: rise and present the MSB
        if (phase_end) begin
          link_d.sclk = 1'h1;
          link_d.dout = link_q.sh_tx[FRAME_BITS-1];
          link_d.sh_tx = {link_q.sh_tx[FRAME_BITS-2:0], 1'h0};
          link_d.cnt = HALF_LOAD;
          link_d.st = LK_HIGH;
        end
      end
      LK_HIGH: begin
        // Second edge: the driver samples here
        if (phase_end) begin
          link_d.sclk = 1'h0;
          link_d.cnt = HALF_LOAD;
          link_d.st = LK_LOW;
        end
      end
      LK_LOW: begin
        // Filtered input now shows the level from around the falling edge
        if (phase_end) begin
          link_d.sh_rx = {link_q.sh_rx[FRAME_BITS-2:0], din_if.clean};
          link_d.cnt = HALF_LOAD;
          if (link_q.bit_idx == LAST_BIT) begin
            link_d.st = LK_TRAIL;
          end else begin
            link_d.bit_idx = link_q.bit_idx + BIT_IDX_W'(1);
            link_d.sclk = 1'h1;
            link_d.dout = link_q.sh_tx[FRAME_BITS-1];
            link_d.sh_tx = {link_q.sh_tx[FRAME_BITS-2:0], 1'h0};
            link_d.st = LK_HIGH;
          end
        end
      end
      LK_TRAIL: begin
        // Select held two half periods after the last falling edge, then released
        if (phase_end) begin
          link_d.cs_n = CS_IDLE_N;
          link_d.dout = DOUT_IDLE;
          link_d.rx_word = link_q.sh_rx;
          link_d.ack = ~link_q.ack;
          link_d.cnt = HALF_LOAD;
          link_d.st = LK_GAP;
        end
      end
      LK_GAP: begin
        // Guarantees select stays high between frames
        if (phase_end) begin
          link_d.st = LK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      link_q <= '{st: LK_IDLE, cnt: CNT_RST, bit_idx: BIT_RST, sh_tx: WORD_RST,
                  sh_rx: WORD_RST, rx_word: WORD_RST, req_seen: 1'h0, ack: 1'h0,
                  sclk: SCLK_IDLE, cs_n: CS_IDLE_N, dout: DOUT_IDLE};
    end else begin
      link_q <= link_d;
    end
  end

  // Pins straight from flops, so no glitches reach the driver
  assign sclk = link_q.sclk;
  assign cs_n = link_q.cs_n;
  assign data_line_out = link_q.dout;

endmodule // gdsm_master

// ==== verif/gdsm_master_asserts.sv ====
// Port checker for the gate driver serial master.
// Assumes the default link period, so one half bit is three link cycles.
`timescale 1ns/10ps
module gdsm_master_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic start,
  input wire logic clear_done,
  input wire logic busy,
  input wire logic done,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic data_line_out
);
  logic [4:0] rise_q;
  // Serial clock rises inside one select window
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) rise_q <= 5'h00;
    else if (cs_n) rise_q <= 5'h00;
    else if ($rose(sclk)) rise_q <= rise_q + 5'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Phases of one bit and of the frame lead-in
  sequence s_high_phase;
    sclk [*3] ##1 !sclk;
  endsequence
  sequence s_lead_in;
    !sclk [*2] ##[1:3] sclk;
  endsequence
  chk_sclk_idle_low: assert property (@(posedge link_clk) disable iff (rst)
    cs_n |-> !sclk) else $error("sclk high while deselected");
  chk_lead_in_delay: assert property (@(posedge link_clk) disable iff (rst)
    $fell(cs_n) |-> s_lead_in) else $error("first sclk rise late");
  chk_sclk_high_len: assert property (@(posedge link_clk) disable iff (rst)
    $rose(sclk) |-> s_high_phase) else $error("sclk high phase wrong");
  chk_sclk_low_len: assert property (@(posedge link_clk) disable iff (rst)
    $fell(sclk) |-> !sclk [*3]) else $error("sclk low phase short");
  chk_dout_on_rise: assert property (@(posedge link_clk) disable iff (rst)
    $changed(data_line_out) |-> $rose(sclk) || $rose(cs_n)) else $error("dout moved");
  chk_frame_bits: assert property (@(posedge link_clk) disable iff (rst)
    $rose(cs_n) |-> rise_q == 5'h10) else $error("frame not sixteen clocks");
  chk_select_gap: assert property (@(posedge link_clk) disable iff (rst)
    $rose(cs_n) |-> cs_n [*3]) else $error("select gap short");
  chk_start_taken: assert property (@(posedge sys_clk) disable iff (rst)
    start && !busy |=> busy) else $error("start not taken");
  chk_done_on_end: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(busy) |-> done) else $error("done missing at end");
  chk_done_clear: assert property (@(posedge sys_clk) disable iff (rst)
    clear_done && !busy |=> !done) else $error("done not cleared");
endmodule // gdsm_master_asserts

bind gdsm_master gdsm_master_asserts i_chk (.sys_clk(sys_clk), .rst(rst),
  .link_clk(link_clk), .start(start), .clear_done(clear_done), .busy(busy),
  .done(done), .sclk(sclk), .cs_n(cs_n), .data_line_out(data_line_out));

// ==== verif/gdsm_drv_model.sv ====
// Behavioural far-side gate driver: mode 1 slave, 16-bit frames.
// Assumes the master owns sclk and cs_n; the data line has no pull.
`timescale 1ns/10ps
module gdsm_drv_model (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic data_line_out,
  output logic data_line_in,
  input wire logic [15:0] reply,
  output logic [15:0] got,
  output logic [7:0] bits
);
  logic din_q = 1'h0;
  logic [15:0] got_q = 16'h0000;
  logic [7:0] bits_q = 8'h00;
  logic sclk_was = 1'h0;
  logic cs_n_was = 1'h1;
  int idx = 15;

  assign data_line_in = din_q;
  assign got = got_q;
  assign bits = bits_q;

  // One process owns all model state, so no variable has two writers
  always @(sclk or cs_n) begin
    // New frame rewinds the pointers
    if (cs_n_was === 1'h1 && cs_n === 1'h0) begin
      idx = 15;
      bits_q = 8'h00;
    end
    // Released line: show inverse of last bit, never a stale copy
    if (cs_n_was === 1'h0 && cs_n === 1'h1) begin
      din_q <= ~din_q;
    end
    // Shift out on rise, MSB first, so data is settled by the fall
    if (cs_n === 1'h0 && sclk_was === 1'h0 && sclk === 1'h1 && idx >= 0) begin
      din_q <= reply[idx];
      idx = idx - 1;
    end
    // Sample on the second edge
    if (cs_n === 1'h0 && sclk_was === 1'h1 && sclk === 1'h0) begin
      got_q <= {got_q[14:0], data_line_out};
      bits_q <= bits_q + 8'h01;
    end
    sclk_was = sclk;
    cs_n_was = cs_n;
  end
endmodule // gdsm_drv_model

// ==== verif/tb.sv ====
// Self-checking bench for the gate driver serial master.
// Assumes 25 ns system clock, 48 ns link clock and the far-side model.
`timescale 1ns/10ps
module tb;
  import gdsm_pkg::*;
  logic sys_clk = 1'h0, link_clk = 1'h0, rst = 1'h1, start = 1'h0, clear_done = 1'h0;
  logic [15:0] tx_data = 16'h0000, reply = 16'h0000, rx_data, got, w;
  logic busy, done, sclk, cs_n, data_line_out, data_line_in;
  logic [7:0] bits;
  logic [31:0] seed = 32'h0001_59A0;
  int err_total = 0, n_compared = 0;
  // Clocks unrelated in phase
  initial forever #12.5 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  gdsm_master #(.LINK_PERIOD_PS(48000)) i_dut (.sys_clk, .rst, .link_clk, .start, .tx_data,
    .clear_done, .busy, .done, .rx_data, .sclk, .cs_n, .data_line_out, .data_line_in);
  gdsm_drv_model i_peer (.sclk, .cs_n, .data_line_out, .data_line_in, .reply, .got, .bits);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Reset levels of every output
  task automatic check_idle;
    check("idle flags", {14'h0000, busy, done}, 16'h0000);
    check("idle pins", {13'h0000, sclk, cs_n, data_line_out}, 16'h0002);
    check("idle rx_data", rx_data, 16'h0000);
  endtask
  task automatic finish_test;
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One frame, entered at a falling edge; clears done while starting
  task automatic run_frame(input logic [15:0] tx, input logic [15:0] rep);
    int i;
    reply = rep;
    start = 1'h1;
    tx_data = tx;
    clear_done = 1'h1;
    @(negedge sys_clk);
    check("busy", {15'h0000, busy}, 16'h0001);
    check("done", {15'h0000, done}, 16'h0000);
    tx_data = ~tx;
    clear_done = 1'h0;
    @(negedge sys_clk);
    start = 1'h0;
    for (i = 0; i < 400 && busy !== 1'h0; i++) @(negedge sys_clk);
    check("busy end", {15'h0000, busy}, 16'h0000);
    check("done end", {15'h0000, done}, 16'h0001);
    check("rx_data", rx_data, rep);
    check("peer word", got, tx);
    check("peer bits", {8'h00, bits}, 16'h0010);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Corners, then random words back to back
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    check_idle();
    rst = 1'h0;
    run_frame(16'h0000, 16'hFFFF);
    run_frame(16'hFFFF, 16'h0000);
    run_frame(16'h8001, 16'h7FFE);
    run_frame(16'h7FFE, 16'h8001);
    repeat (8) begin
      seed = xs(seed);
      w = seed[15:0];
      run_frame(w, seed[31:16]);
    end
    // Reset in mid-frame: pins and flags fall back to idle, then a frame runs clean
    start = 1'h1;
    tx_data = 16'h5A3C;
    @(negedge sys_clk);
    start = 1'h0;
    repeat (60) @(negedge sys_clk);
    check("mid select", {15'h0000, cs_n}, 16'h0000);
    rst = 1'h1;
    repeat (8) @(negedge sys_clk);
    check_idle();
    rst = 1'h0;
    run_frame(16'hC3A5, 16'h3CA5);
    clear_done = 1'h1;
    @(negedge sys_clk);
    check("done cleared", {15'h0000, done}, 16'h0000);
    finish_test();
  end
  // Hang guard, about three times the expected run
  initial begin
    #200_000;
    err_total++;
    finish_test();
  end
endmodule // tb
